/* design/rtc_spi_device.sv */
// serial slave access port of the battery-backed clock with ram
module rtc_spi_device #(
  parameter int unsigned REC_CYCLES = rtc_spi_pkg::REC_DELAY_CYC
) (
  input  wire logic                             clk_sys,
  input  wire logic                             rst,
  spi_link_if.device                            link,
  input  wire logic                             power_fail,
  input  wire logic                             on_battery,
  output logic      [rtc_spi_pkg::PTR_W-1:0]    mem_addr,
  output logic      [rtc_spi_pkg::DATA_W-1:0]   mem_wdata,
  output logic                                  mem_we,
  input  wire logic [rtc_spi_pkg::DATA_W-1:0]   mem_rdata,
  output logic                                  clock_hold,
  output logic                                  reset_out,
  output logic                                  reset_out_oe
);
  import rtc_spi_pkg::*;

  localparam int unsigned REC_W = $clog2(REC_CYCLES + 1);
  localparam logic [REC_W-1:0] REC_LOAD = REC_W'(REC_CYCLES);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CMD,
    ST_WRITE,
    ST_READ
  } dev_state_t;

  typedef struct packed {
    dev_state_t        st;
    logic [1:0]        sel_sy;
    logic [2:0]        sck_sy;
    logic [1:0]        din_sy;
    logic [1:0]        pf_sy;
    logic [1:0]        bat_sy;
    logic              sel_prev;
    logic [2:0]        bitcnt;
    logic [DATA_W-1:0] shift;
    logic [DATA_W-1:0] tx;
    logic              load;
    logic [PTR_W-1:0]  ptr;
    logic [PTR_W-1:0]  addr;
    logic [DATA_W-1:0] wdata;
    logic              we;
    logic              dout;
    logic              dout_oe;
    logic              protect;
    logic [REC_W-1:0]  rec_cnt;
    logic              hold;
    logic              rst_oe;
  } dev_regs_t;

  dev_regs_t s_r;
  dev_regs_t s_nxt;

  logic              sck_rise;
  logic              sck_fall;
  logic              din_bit;
  logic              pf;
  logic              bat;
  logic              sel_eff;
  logic [DATA_W-1:0] byte_in;

  always_comb begin
    s_nxt = s_r;
    // first stage of each synchroniser feeds only its second stage
    s_nxt.sel_sy = {s_r.sel_sy[0], link.select_n};
    s_nxt.sck_sy = {s_r.sck_sy[1:0], link.sclk};
    s_nxt.din_sy = {s_r.din_sy[0], link.serial_data_in};
    s_nxt.pf_sy  = {s_r.pf_sy[0], power_fail};
    s_nxt.bat_sy = {s_r.bat_sy[0], on_battery};

    sck_rise = s_r.sck_sy[1] & ~s_r.sck_sy[2];
    sck_fall = ~s_r.sck_sy[1] & s_r.sck_sy[2];
    din_bit  = s_r.din_sy[1];
    pf       = s_r.pf_sy[1];
    bat      = s_r.bat_sy[1];
    byte_in  = {s_r.shift[DATA_W-2:0], din_bit};
    s_nxt.we = 1'b0;

    // write protection holds on until the recovery delay has run out
    if (pf | bat) begin
      s_nxt.protect = 1'b1;
      s_nxt.rec_cnt = REC_LOAD;
    end else if (s_r.protect) begin
      if (s_r.rec_cnt == '0) begin
        s_nxt.protect = 1'b0;
      end else begin
        s_nxt.rec_cnt = s_r.rec_cnt - 1'b1;
      end
    end

    // protection forces select inactive internally
    sel_eff = s_r.sel_sy[1] | s_r.protect;
    // edges come from the pin, not from sel_eff: the end of protection with
    // select already low must not look like a falling edge
    s_nxt.sel_prev = s_r.sel_sy[1];

    if (pf) begin
      s_nxt.st      = ST_IDLE;
      s_nxt.ptr     = PTR_RESET;
      s_nxt.bitcnt  = BIT_FIRST;
      s_nxt.load    = 1'b0;
      s_nxt.dout_oe = 1'b0;
    end else if (sel_eff) begin
      // deselect drops any partial byte without writing it
      s_nxt.st      = ST_IDLE;
      s_nxt.bitcnt  = BIT_FIRST;
      s_nxt.load    = 1'b0;
      s_nxt.dout_oe = 1'b0;
    end else if (s_r.sel_prev & ~s_r.sel_sy[1]) begin
      // only a fall seen outside protection arms a frame; a fall hidden by it is lost
      s_nxt.st      = ST_CMD;
      s_nxt.bitcnt  = BIT_FIRST;
      s_nxt.load    = 1'b0;
      s_nxt.dout_oe = 1'b0;
    end else begin
      unique case (s_r.st)
        ST_IDLE: begin
        end
        ST_CMD: begin
          if (sck_rise) begin
            s_nxt.shift  = byte_in;
            s_nxt.bitcnt = s_r.bitcnt + 3'h1;
            if (s_r.bitcnt == BIT_LAST) begin
              s_nxt.ptr = byte_in[PTR_W-1:0];
              if (byte_in[DIR_BIT] == DIR_WRITE) begin
                s_nxt.st = ST_WRITE;
              end else begin
                s_nxt.st   = ST_READ;
                s_nxt.load = 1'b1;
              end
            end
          end
        end
        ST_WRITE: begin
          if (sck_rise) begin
            s_nxt.shift  = byte_in;
            s_nxt.bitcnt = s_r.bitcnt + 3'h1;
            if (s_r.bitcnt == BIT_LAST) begin
              s_nxt.we    = 1'b1;
              s_nxt.wdata = byte_in;
              s_nxt.ptr   = s_r.ptr + 1'b1;
            end
          end
        end
        ST_READ: begin
          // read data arrives a cycle after the pointer moves
          if (s_r.load) begin
            s_nxt.tx   = mem_rdata;
            s_nxt.load = 1'b0;
          end
          if (sck_rise) begin
            s_nxt.bitcnt = s_r.bitcnt + 3'h1;
            if (s_r.bitcnt == BIT_LAST) begin
              s_nxt.ptr  = s_r.ptr + 1'b1;
              s_nxt.load = 1'b1;
            end
          end
          // output stays undriven until the first full byte is in the shifter
          if (sck_fall && !s_r.load) begin
            s_nxt.dout_oe = 1'b1;
            s_nxt.dout    = s_r.tx[DATA_W-1];
            s_nxt.tx      = {s_r.tx[DATA_W-2:0], 1'b0};
          end
        end
      endcase
    end

    // a write holds the address of its own byte for the strobe cycle
    s_nxt.addr = s_nxt.we ? s_r.ptr : s_nxt.ptr;

    s_nxt.hold = ((s_nxt.st == ST_READ) || (s_nxt.st == ST_WRITE)) &&
                 (s_nxt.ptr <= PTR_CLOCK_LAST);

    if (bat) begin
      s_nxt.dout_oe = 1'b0;
    end
    s_nxt.rst_oe = s_nxt.protect & ~bat;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // power-up counts as a supply return: protection and reset start active
      s_r         <= '0;
      s_r.protect <= 1'b1;
      s_r.rec_cnt <= REC_LOAD;
      s_r.rst_oe  <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.serial_data_out    = s_r.dout;
  assign link.serial_data_out_oe = s_r.dout_oe;
  assign mem_addr                = s_r.addr;
  assign mem_wdata               = s_r.wdata;
  assign mem_we                  = s_r.we;
  assign clock_hold              = s_r.hold;
  // open drain: the pin is only ever pulled low
  assign reset_out               = 1'b0;
  assign reset_out_oe            = s_r.rst_oe;

endmodule : rtc_spi_device

/* common/rtc_spi_pkg.sv */
// shared constants for the real-time clock serial access port and its master
package rtc_spi_pkg;

  localparam int unsigned SYS_CLK_NS     = 100;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned ADDR_W         = 7;
  localparam int unsigned PTR_W          = 6;
  localparam int unsigned DIR_BIT        = 7;
  localparam int unsigned LEN_W          = 7;
  localparam int unsigned TIMER_W        = 8;

  localparam logic [2:0]       BIT_LAST       = 3'h7;
  localparam logic [2:0]       BIT_FIRST      = 3'h0;
  localparam logic             DIR_WRITE      = 1'h1;
  localparam logic [PTR_W-1:0] PTR_RESET      = 6'h00;
  localparam logic [PTR_W-1:0] PTR_CLOCK_LAST = 6'h07;
  localparam logic [LEN_W-1:0] LEN_ONE        = 7'h01;

  // recovery delay after the supply returns; a least time, rounded up
  localparam int unsigned REC_DELAY_NS   = 100000;
  localparam int unsigned REC_DELAY_CYC  = (REC_DELAY_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

  // select high time before a new frame; a least time, rounded up
  localparam int unsigned SEL_REC_NS     = 200;
  localparam int unsigned SEL_REC_CYC    = (SEL_REC_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

  // serial clock made by the master; half period is a least time, rounded up
  localparam int unsigned SCLK_PERIOD_NS = 1600;
  localparam int unsigned SCLK_HALF_CYC  = (SCLK_PERIOD_NS / 2 + SYS_CLK_NS - 1) / SYS_CLK_NS;

  localparam logic [TIMER_W-1:0] HALF_LOAD = TIMER_W'(SCLK_HALF_CYC - 1);
  localparam logic [TIMER_W-1:0] GAP_LOAD  = TIMER_W'(SEL_REC_CYC);

endpackage : rtc_spi_pkg

/* common/spi_link_if.sv */
// serial link between the clock device and its master
interface spi_link_if;
  logic select_n;
  logic sclk;
  logic serial_data_in;
  logic serial_data_out;
  logic serial_data_out_oe;
  logic serial_data_out_line;

  // pull-up on the shared data-out wire while nobody drives it
  assign serial_data_out_line = serial_data_out_oe ? serial_data_out : 1'b1;

  modport device (
    input  select_n,
    input  sclk,
    input  serial_data_in,
    output serial_data_out,
    output serial_data_out_oe
  );

  modport host (
    output select_n,
    output sclk,
    output serial_data_in,
    input  serial_data_out_line
  );
endinterface : spi_link_if

/* design/rtc_spi_host.sv */
// spi master that drives the clock device's serial access port
module rtc_spi_host (
  input  wire logic                            clk_sys,
  input  wire logic                            rst,
  spi_link_if.host                             link,
  input  wire logic                            cpol,
  input  wire logic                            cmd_valid,
  output logic                                 cmd_ready,
  input  wire logic                            cmd_write,
  input  wire logic [rtc_spi_pkg::ADDR_W-1:0]  cmd_addr,
  input  wire logic [rtc_spi_pkg::LEN_W-1:0]   cmd_len,
  input  wire logic [rtc_spi_pkg::DATA_W-1:0]  wr_data,
  output logic                                 wr_take,
  output logic      [rtc_spi_pkg::DATA_W-1:0]  rd_data,
  output logic                                 rd_valid,
  output logic                                 busy
);
  import rtc_spi_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE,
    H_LEAD,
    H_LOW,
    H_HIGH,
    H_TAIL
  } host_state_t;

  typedef struct packed {
    host_state_t        st;
    logic [TIMER_W-1:0] timer;
    logic               sel;
    logic               sck;
    logic               mosi;
    logic [DATA_W-1:0]  tx;
    logic [DATA_W-1:0]  rx;
    logic [2:0]         bitcnt;
    logic [LEN_W-1:0]   left;
    logic               in_cmd;
    logic               write;
    logic               last;
    logic [1:0]         miso_sy;
    logic [DATA_W-1:0]  rd_data;
    logic               rd_valid;
    logic               wr_take;
  } host_regs_t;

  host_regs_t s_r;
  host_regs_t s_nxt;
  logic       miso;
  logic       byte_end;

  assign cmd_ready = (s_r.st == H_IDLE) && (s_r.timer == '0);

  always_comb begin
    s_nxt          = s_r;
    s_nxt.miso_sy  = {s_r.miso_sy[0], link.serial_data_out_line};
    s_nxt.rd_valid = 1'b0;
    s_nxt.wr_take  = 1'b0;
    miso           = s_r.miso_sy[1];
    byte_end       = s_r.bitcnt == BIT_LAST;
    if (s_r.timer != '0) begin
      s_nxt.timer = s_r.timer - 1'b1;
    end
    unique case (s_r.st)
      H_IDLE: begin
        s_nxt.sel = 1'b1;
        s_nxt.sck = cpol;
        if (cmd_valid && cmd_ready) begin
          // the falling select edge opens every frame
          s_nxt.st     = H_LEAD;
          s_nxt.sel    = 1'b0;
          s_nxt.tx     = {cmd_write, cmd_addr};
          s_nxt.mosi   = cmd_write;
          s_nxt.write  = cmd_write;
          s_nxt.left   = (cmd_len == '0) ? LEN_ONE : cmd_len;
          s_nxt.in_cmd = 1'b1;
          s_nxt.last   = 1'b0;
          s_nxt.bitcnt = BIT_FIRST;
          s_nxt.timer  = HALF_LOAD;
        end
      end
      H_LEAD: begin
        if (s_r.timer == '0) begin
          s_nxt.st    = H_LOW;
          s_nxt.sck   = 1'b0;
          s_nxt.mosi  = s_r.tx[DATA_W-1];
          s_nxt.timer = HALF_LOAD;
        end
      end
      H_LOW: begin
        if (s_r.timer == '0) begin
          s_nxt.st     = H_HIGH;
          s_nxt.sck    = 1'b1;
          s_nxt.timer  = HALF_LOAD;
          s_nxt.rx     = {s_r.rx[DATA_W-2:0], miso};
          s_nxt.tx     = {s_r.tx[DATA_W-2:0], 1'b0};
          s_nxt.bitcnt = s_r.bitcnt + 3'h1;
          if (byte_end) begin
            if (!s_r.in_cmd) begin
              s_nxt.left = s_r.left - 1'b1;
              if (!s_r.write) begin
                s_nxt.rd_data  = {s_r.rx[DATA_W-2:0], miso};
                s_nxt.rd_valid = 1'b1;
              end
            end
            s_nxt.in_cmd = 1'b0;
            s_nxt.last   = !s_r.in_cmd && (s_r.left == LEN_ONE);
            if (s_r.write && (s_r.in_cmd || (s_r.left != LEN_ONE))) begin
              s_nxt.tx      = wr_data;
              s_nxt.wr_take = 1'b1;
            end
          end
        end
      end
      H_HIGH: begin
        if (s_r.timer == '0) begin
          s_nxt.timer = HALF_LOAD;
          if (s_r.last) begin
            s_nxt.st  = H_TAIL;
            s_nxt.sck = cpol;
          end else begin
            s_nxt.st   = H_LOW;
            s_nxt.sck  = 1'b0;
            s_nxt.mosi = s_r.tx[DATA_W-1];
          end
        end
      end
      H_TAIL: begin
        if (s_r.timer == '0) begin
          s_nxt.st    = H_IDLE;
          s_nxt.sel   = 1'b1;
          s_nxt.timer = GAP_LOAD;
        end
      end
      default: begin
        s_nxt.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // select starts high and the gap timer runs before the first frame
      s_r       <= '0;
      s_r.sel   <= 1'b1;
      s_r.timer <= GAP_LOAD;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.select_n       = s_r.sel;
  assign link.sclk           = s_r.sck;
  assign link.serial_data_in = s_r.mosi;
  assign wr_take             = s_r.wr_take;
  assign rd_data             = s_r.rd_data;
  assign rd_valid            = s_r.rd_valid;
  assign busy                = s_r.st != H_IDLE;

endmodule : rtc_spi_host

/* dv/rtc_spi_props.sv */
// concurrent checks on the serial link between the clock device and its master
module rtc_spi_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic select_n,
  input wire logic sclk,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] rise_cnt_r;
  logic       sclk_r;
  logic       wr_frame_r;

  // raw clock rises inside a frame; the device sees them later through its synchroniser
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sclk_r     <= 1'b0;
      rise_cnt_r <= 10'h000;
      wr_frame_r <= 1'b0;
    end else begin
      sclk_r <= sclk;
      if (select_n)
        rise_cnt_r <= 10'h000;
      else if (sclk && !sclk_r)
        rise_cnt_r <= rise_cnt_r + 10'h001;
      if (!select_n && sclk && !sclk_r && rise_cnt_r == 10'h000)
        wr_frame_r <= serial_data_in;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_frame_open;
    $fell(select_n);
  endsequence
  sequence s_sclk_still;
    $stable(sclk) [*4];
  endsequence
  sequence s_deselect;
    $rose(select_n);
  endsequence

  a_first_edge_wait: assert property (s_frame_open |-> s_sclk_still)
    else $error("serial clock moved right after select fell");
  a_din_hold_rise: assert property ($rose(sclk) && !select_n |=> $stable(serial_data_in))
    else $error("data in changed across the sampling rise");
  a_dout_after_fall: assert property (serial_data_out_oe && $past(serial_data_out_oe) && $changed(serial_data_out)
    |-> !sclk)
    else $error("data out changed while the serial clock was high");
  a_oe_off_deselect: assert property (select_n [*5] |-> !serial_data_out_oe)
    else $error("data out driven while deselected");
  a_oe_needs_select: assert property (serial_data_out_oe |-> !$past(select_n, 4))
    else $error("data out driven too long after deselect");
  a_byte_whole: assert property (s_deselect |-> rise_cnt_r[2:0] == 3'h0)
    else $error("frame ended inside a byte");
  a_oe_first_byte: assert property ($rose(serial_data_out_oe) |-> rise_cnt_r == 10'h008)
    else $error("data out enabled at the wrong bit");
  a_write_quiet: assert property (wr_frame_r && rise_cnt_r != 10'h000 |-> !serial_data_out_oe)
    else $error("data out driven in a write frame");
  a_select_gap: assert property (s_deselect |-> select_n [*3])
    else $error("select high time too short");
endmodule : rtc_spi_props

/* dv/rtc_spi_slave_access_port_tb_top.sv */
// bench joining the clock device port to its master, plus a hand-driven second device
module rtc_spi_slave_access_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int REC = 8;
  logic       clk_sys = 0, rst = 1, cpol = 0, cmd_valid = 0, cmd_write = 0;
  logic       power_fail = 0, on_battery = 0, hold_seen;
  logic [6:0] cmd_addr = 0, cmd_len = 1;
  logic [7:0] wr_data = 0, rd_data, mem_wdata, mem_wdata2, we2_d;
  logic [5:0] mem_addr, mem_addr2, we2_a;
  logic       cmd_ready, wr_take, rd_valid, busy, mem_we, mem_we2, clock_hold, reset_out_oe, reset_out;
  logic [7:0] mem [64];
  logic [7:0] rq [$];
  int         fail_count = 0, n_tests = 0, cyc = 0, we2_n = 0;
  spi_link_if link ();
  spi_link_if link2 ();
  rtc_spi_host rtc_spi_host_i (.clk_sys(clk_sys), .rst(rst), .link(link), .cpol(cpol), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_data(wr_data),
    .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy));
  rtc_spi_device #(.REC_CYCLES(REC)) rtc_spi_device_i (.clk_sys(clk_sys), .rst(rst), .link(link),
    .power_fail(power_fail), .on_battery(on_battery), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .mem_rdata(mem[mem_addr]), .clock_hold(clock_hold), .reset_out(reset_out),
    .reset_out_oe(reset_out_oe));
  rtc_spi_device #(.REC_CYCLES(REC)) rtc_spi_device_i2 (.clk_sys(clk_sys), .rst(rst), .link(link2),
    .power_fail(1'b0), .on_battery(1'b0), .mem_addr(mem_addr2), .mem_wdata(mem_wdata2), .mem_we(mem_we2),
    .mem_rdata(8'h00), .clock_hold(), .reset_out(), .reset_out_oe());
  rtc_spi_props rtc_spi_props_i (.clk_sys(clk_sys), .rst(rst), .select_n(link.select_n), .sclk(link.sclk),
    .serial_data_in(link.serial_data_in), .serial_data_out(link.serial_data_out),
    .serial_data_out_oe(link.serial_data_out_oe));

  initial forever #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (mem_we)
      mem[mem_addr] <= mem_wdata;
    if (mem_we2) begin
      we2_n <= we2_n + 1;
      we2_d <= mem_wdata2;
      we2_a <= mem_addr2;
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("tests %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // cut > 0 drops the supply (or goes to battery) that many cycles into the frame
  task automatic xfer(input logic w, input logic [6:0] a, n, input logic [7:0] d, input int cut = 0,
                      input logic bat = 0);
    int i;
    i = 0;
    rq.delete();
    hold_seen = 0;
    @(negedge clk_sys);
    cmd_write = w;
    cmd_addr = a;
    cmd_len = n;
    wr_data = d;
    cmd_valid = 1;
    while (cmd_ready !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
    cmd_valid = 0;
    while (busy === 1'b1) begin
      i++;
      if (i == cut)
        {on_battery, power_fail} = {bat, !bat};
      if (bat && i == cut + 4)
        check({6'h0, reset_out_oe, link.serial_data_out_oe}, 8'h00);
      if (wr_take)
        wr_data = wr_data + 8'h11;
      if (rd_valid)
        rq.push_back(rd_data);
      hold_seen |= clock_hold;
      @(negedge clk_sys);
    end
    repeat (4) @(negedge clk_sys);
    check({7'h0, clock_hold}, 8'h00);
  endtask : xfer

  // second device: bits go out mode 0,0 at twice the bench link clock rate
  task automatic send(input logic [15:0] v, input int n);
    for (int b = 15; b > 15 - n; b--) begin
      link2.serial_data_in = v[b];
      repeat (4) @(negedge clk_sys);
      link2.sclk = 1;
      repeat (4) @(negedge clk_sys);
      link2.sclk = 0;
    end
  endtask : send

  task automatic t_partial();
    send(16'h853c, 16);
    link2.select_n = 1;
    repeat (4) @(negedge clk_sys);
    send(16'h853c, 16);
    link2.select_n = 0;
    repeat (4) @(negedge clk_sys);
    send(16'h853c, 12);
    link2.select_n = 1;
    repeat (4) @(negedge clk_sys);
    check(8'(we2_n), 8'h00);
    link2.select_n = 0;
    repeat (4) @(negedge clk_sys);
    send(16'h853c, 16);
    repeat (4) @(negedge clk_sys);
    link2.select_n = 1;
    check(8'(we2_n), 8'h01);
    check({2'h0, we2_a}, 8'h05);
    check(we2_d, 8'h3c);
    $display("partial byte test done");
  endtask : t_partial

  task automatic t_write_wrap();
    xfer(1, 7'h7e, 3, 8'ha1);
    check(mem[6'h3e], 8'ha1);
    check(mem[6'h3f], 8'hb2);
    check(mem[6'h00], 8'hc3);
    check({7'h0, hold_seen}, 8'h01);
    cpol = 1;
    xfer(0, 7'h3f, 2, 8'h00);
    check(rq[0], 8'hb2);
    check(rq[1], 8'hc3);
    check(8'(rq.size()), 8'h02);
    cpol = 0;
    $display("write wrap test done");
  endtask : t_write_wrap

  task automatic t_hold();
    xfer(0, 7'h47, 2, 8'h00);
    check(rq[0], 8'h5d);
    check(rq[1], 8'h52);
    check({7'h0, hold_seen}, 8'h01);
    xfer(1, 7'h10, 2, 8'h30);
    check({7'h0, hold_seen}, 8'h00);
    xfer(0, 7'h50, 2, 8'h00);
    check(rq[0], 8'h30);
    check(rq[1], 8'h41);
    $display("clock hold test done");
  endtask : t_hold

  task automatic t_supply();
    xfer(1, 7'h20, 3, 8'h11, 180, 0);
    check({6'h0, reset_out_oe, reset_out}, 8'h02);
    check(mem[6'h20], 8'h7a);
    power_fail = 0;
    repeat (4) @(negedge clk_sys);
    check({7'h0, reset_out_oe}, 8'h01);
    repeat (REC + 8) @(negedge clk_sys);
    check({7'h0, reset_out_oe}, 8'h00);
    // a zero length still moves one byte
    xfer(1, 7'h30, 0, 8'h66);
    xfer(0, 7'h30, 3, 8'h00, 200, 1);
    on_battery = 0;
    repeat (REC + 12) @(negedge clk_sys);
    xfer(0, 7'h30, 1, 8'h00);
    check(rq[0], 8'h66);
    $display("supply test done");
  endtask : t_supply

  initial begin
    for (int i = 0; i < 64; i++)
      mem[i] = 8'(i) ^ 8'h5a;
    link2.select_n = 0;
    link2.sclk = 0;
    link2.serial_data_in = 0;
    repeat (3) @(negedge clk_sys);
    rst = 0;
    repeat (REC + 12) @(negedge clk_sys);
    t_partial();
    t_write_wrap();
    t_hold();
    t_supply();
    test_done();
  end
endmodule : rtc_spi_slave_access_port_tb_top
